// ===== verilog/bus_sizer_map.svh
/*
 * Constants of the bus sizing and takeover sequencer: port width codes,
 * status codes, reset values and lane layout.
 * Assumes inclusion by bare name from the package and the design module.
 */
//
// Contract
// - 16-bit cacheable read adds the other-word cycle, all enables low.
// - 16-bit uncached read adds a cycle only for bytes in the other word.
// - 8-bit cached read does four wrapping byte cycles; uncached only needed ones.
// - Writes present the exact operand address and enable only written lanes.
// - Write data of upper lanes is copied onto lower lanes for narrow ports.
// - Unused write lanes are don't-care; memory must not rely on them.
// - On a 32-bit port any write completes in one bus cycle.
// - 16-bit write takes at most two cycles; second addresses upper word.
// - Second 16-bit write cycle puts original lane-2 byte on lane 0.
// - 8-bit write takes up to four cycles, byte on lane 0, enables shifting.
// - A single byte written at lane 3 also appears on lanes 0 and 1.
// - Master requests takeover; after grant the device has released its outputs.
// - Master drops its request; device drops grant and takes the bus back.
// - Takeover request is sampled in every bus state.
// - A request seen while idle between sequences is granted at once unless a locked read awaits its write; an operand accepted that cycle goes first.
// - During a sequence, grant waits until it ends, retries included.
// - All narrow-port cycles of one operand are indivisible; no grant between.
// - Cacheable narrow-port reads fetch the whole doubleword for the cache.
// - No grant between read and write of an interlocked operation.
// - While the bus is granted, the status outputs show idle.
`ifndef BUS_SIZER_MAP_SVH
`define BUS_SIZER_MAP_SVH

// =====================================================================
// Port width codes returned by memory with each cycle's acknowledge
`define WIDTH_8 2'h0
`define WIDTH_16 2'h1
`define WIDTH_32 2'h2

// =====================================================================
// Bus status codes
`define STATUS_IDLE 5'h00
`define STATUS_READ 5'h0a
`define STATUS_WRITE 5'h0b

// =====================================================================
// Enables and reset values
`define BE_ALL_ON_N 4'h0
`define BE_ALL_OFF_N 4'hf
`define LANES_ALL 4'hf
`define LANES_LOW_WORD 4'h3
`define LANES_HIGH_WORD 4'hc
`define LANE_BYTE0 4'h1
`define ADDR_RESET 32'h0000_0000
`define DATA_RESET 32'h0000_0000

`endif

// ===== verilog/bus_sizer_pkg.sv
/*
 * Types of the bus sizing and takeover sequencer.
 * Assumes the constant header is on the include path.
 */
`include "bus_sizer_map.svh"

package bus_sizer_pkg;

    // =================================================================
    // Operand request from the processor side
    typedef struct packed {
        logic [31:0] addr;
        logic [1:0] size;
        logic write;
        logic cacheable;
        logic locked;
        logic [31:0] wdata;
    } op_req_type;

    // =================================================================
    // Completion towards the processor side
    typedef struct packed {
        logic valid;
        logic cache_fill;
        logic [31:0] rdata;
    } op_rsp_type;

    // =================================================================
    // Pins driven onto the external bus
    typedef struct packed {
        logic [31:0] addr;
        logic [3:0] byte_lane_enables_n;
        logic [31:0] wdata;
        logic [4:0] bus_status_code;
    } bus_pins_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CYCLE = 3'b010,
        ST_HELD = 3'b100
    } seq_state_type;

endpackage : bus_sizer_pkg

// ===== verilog/bus_sizer.sv
/*
 * Bus sizing sequencer: splits one operand access into 8/16/32-bit port
 * cycles, duplicates write data onto low lanes, fetches whole doublewords
 * for cacheable reads, and hands the bus to an external master.
 * Assumes memory answers on i_clk; the takeover request is asynchronous.
 * Operands never cross a doubleword boundary.
 */
`timescale 1ns/10ps
`include "bus_sizer_map.svh"

module bus_sizer
    import bus_sizer_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_srst,
    input wire op_req_type i_req,
    input wire logic i_req_valid,
    output logic o_req_ready,
    output op_rsp_type o_rsp,
    output bus_pins_type o_pins,
    output logic o_pins_oe,
    output logic o_data_oe,
    input wire logic i_ack,
    input wire logic i_retry,
    input wire logic [1:0] i_width,
    input wire logic [31:0] i_rdata,
    input wire logic i_takeover_req_n,
    output logic o_bus_takeover_grant_n
);

    // =================================================================
    // Takeover request synchroniser
    logic hold_meta_reg;
    logic hold_sync_reg;

    // Request comes from another master's clock, so two stages first
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            hold_meta_reg <= 1'b0;
            hold_sync_reg <= 1'b0;
        end else begin
            hold_meta_reg <= ~i_takeover_req_n;
            hold_sync_reg <= hold_meta_reg;
        end
    end

    // =================================================================
    // Sequence state
    seq_state_type state_reg;
    seq_state_type state_next;
    logic [31:0] addr_reg;
    logic [3:0] rem_reg;
    logic [3:0] fill_reg;
    logic [31:0] wdata_reg;
    logic [31:0] rbuf_reg;
    logic write_reg;
    logic cach_reg;
    logic lock_reg;

    logic take;
    logic grant;
    logic finish;
    logic [3:0] req_mask;
    logic [3:0] cov;
    logic [3:0] rem_next;
    logic [3:0] fill_next;
    logic [3:0] need;
    logic [1:0] lsb_next;
    logic [3:0] be_next_n;
    logic [31:0] rbuf_next;
    logic [3:0] keep;

    // Lane 0 takes the byte at the address, lane 1 the byte of the same
    // half; the upper lanes keep their own bytes.
    function automatic logic [31:0] dup_lanes(input logic [31:0] d, input logic [1:0] lsb);
        logic [7:0] lane0;
        logic [7:0] lane1;
        lane0 = d[8*lsb +: 8];
        lane1 = lsb[1] ? d[31:24] : d[15:8];
        dup_lanes = {d[31:16], lane1, lane0};
    endfunction : dup_lanes

    always_comb begin
        req_mask = 4'((5'h2 << i_req.size) - 5'h1) << i_req.addr[1:0];
    end

    assign take = (state_reg == ST_IDLE) && i_req_valid && o_req_ready;
    // Idle requests win at once unless a locked read awaits its write; an accepted operand runs first
    assign grant = (state_reg == ST_IDLE) && !take && hold_sync_reg && !lock_reg;

    // =================================================================
    // Lane coverage of the cycle just acknowledged
    always_comb begin
        unique case (i_width)
            `WIDTH_32: cov = `LANES_ALL;
            `WIDTH_16: cov = addr_reg[1] ? `LANES_HIGH_WORD : `LANES_LOW_WORD;
            default: cov = `LANE_BYTE0 << addr_reg[1:0];
        endcase
        rem_next = rem_reg & ~cov;
        fill_next = fill_reg | cov;
        need = cach_reg ? ~fill_next : rem_next;
        finish = (need == 4'h0) || (i_width == `WIDTH_32);
        // 16-bit ports move to the other word, 8-bit ports step and wrap
        lsb_next = (i_width == `WIDTH_16) ? {~addr_reg[1], 1'b0} : 2'(addr_reg[1:0] + 2'h1);
        be_next_n = cach_reg ? `BE_ALL_ON_N : ~rem_next;
    end

    // =================================================================
    // Read assembly, one lane per instance; uncached reads keep only
    // the selected bytes, so unselected ones read back as zero
    assign keep = cov & (cach_reg ? `LANES_ALL : rem_reg);

    read_lane_capture #(.LANE(0)) lane0_u (
        .i_width(i_width),
        .i_rdata(i_rdata),
        .i_keep(keep[0]),
        .i_old(rbuf_reg[7:0]),
        .o_byte(rbuf_next[7:0])
    );

    read_lane_capture #(.LANE(1)) lane1_u (
        .i_width(i_width),
        .i_rdata(i_rdata),
        .i_keep(keep[1]),
        .i_old(rbuf_reg[15:8]),
        .o_byte(rbuf_next[15:8])
    );

    read_lane_capture #(.LANE(2)) lane2_u (
        .i_width(i_width),
        .i_rdata(i_rdata),
        .i_keep(keep[2]),
        .i_old(rbuf_reg[23:16]),
        .o_byte(rbuf_next[23:16])
    );

    read_lane_capture #(.LANE(3)) lane3_u (
        .i_width(i_width),
        .i_rdata(i_rdata),
        .i_keep(keep[3]),
        .i_old(rbuf_reg[31:24]),
        .o_byte(rbuf_next[31:24])
    );

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (take) begin
                    state_next = ST_CYCLE;
                end else if (grant) begin
                    state_next = ST_HELD;
                end
            end
            ST_CYCLE: begin
                // A retried cycle repeats; the sequence stays unbroken
                if (i_ack && !i_retry && finish) begin
                    state_next = ST_IDLE;
                end
            end
            ST_HELD: begin
                if (!hold_sync_reg) begin
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // =================================================================
    // Operand bookkeeping, one block per concern
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            addr_reg <= `ADDR_RESET;
        end else if (take) begin
            addr_reg <= i_req.addr;
        end else if (state_reg == ST_CYCLE && i_ack && !i_retry) begin
            addr_reg <= {addr_reg[31:2], lsb_next};
        end
    end

    // Lanes still owed to the operand and lanes already fetched
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            rem_reg <= 4'h0;
            fill_reg <= 4'h0;
        end else if (take) begin
            rem_reg <= req_mask;
            fill_reg <= 4'h0;
        end else if (state_reg == ST_CYCLE && i_ack && !i_retry) begin
            rem_reg <= rem_next;
            fill_reg <= fill_next;
        end
    end

    // Write data is latched once; later cycles only re-steer it
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            wdata_reg <= `DATA_RESET;
        end else if (take) begin
            wdata_reg <= i_req.wdata;
        end
    end

    // A retried cycle leaves the buffer alone, so its data never counts
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            rbuf_reg <= `DATA_RESET;
        end else if (take) begin
            rbuf_reg <= `DATA_RESET;
        end else if (state_reg == ST_CYCLE && i_ack && !i_retry) begin
            rbuf_reg <= rbuf_next;
        end
    end

    // Cacheable only matters for reads; writes never fill the cache
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            write_reg <= 1'b0;
            cach_reg <= 1'b0;
        end else if (take) begin
            write_reg <= i_req.write;
            cach_reg <= i_req.cacheable && !i_req.write;
        end
    end

    // Interlock spans from the locked read to the end of the next write
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            lock_reg <= 1'b0;
        end else if (take && i_req.locked && !i_req.write) begin
            lock_reg <= 1'b1;
        end else if (state_reg == ST_CYCLE && state_next == ST_IDLE && write_reg) begin
            lock_reg <= 1'b0;
        end
    end

    // =================================================================
    // Bus pins
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_pins.addr <= `ADDR_RESET;
            o_pins.byte_lane_enables_n <= `BE_ALL_OFF_N;
            o_pins.wdata <= `DATA_RESET;
            o_pins.bus_status_code <= `STATUS_IDLE;
            o_data_oe <= 1'b0;
        end else if (take) begin
            o_pins.addr <= i_req.addr;
            o_pins.byte_lane_enables_n <= ~req_mask;
            // Lanes 2 and 3 carry whatever the operand had there; lanes 0 and 1 get copies
            o_pins.wdata <= dup_lanes(i_req.wdata, i_req.addr[1:0]);
            o_pins.bus_status_code <= i_req.write ? `STATUS_WRITE : `STATUS_READ;
            o_data_oe <= i_req.write;
        end else if (state_reg == ST_CYCLE && i_ack && !i_retry) begin
            if (finish) begin
                o_pins.byte_lane_enables_n <= `BE_ALL_OFF_N;
                o_pins.bus_status_code <= `STATUS_IDLE;
                o_data_oe <= 1'b0;
            end else begin
                o_pins.addr <= {addr_reg[31:2], lsb_next};
                o_pins.byte_lane_enables_n <= be_next_n;
                o_pins.wdata <= dup_lanes(wdata_reg, lsb_next);
            end
        end else if (state_reg != ST_CYCLE) begin
            o_pins.bus_status_code <= `STATUS_IDLE;
        end
    end

    // =================================================================
    // Takeover grant and output release
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_bus_takeover_grant_n <= 1'b1;
            o_pins_oe <= 1'b1;
        end else if (grant) begin
            // Release and grant together so the master never sees a driven bus
            o_bus_takeover_grant_n <= 1'b0;
            o_pins_oe <= 1'b0;
        end else if (state_reg == ST_HELD && !hold_sync_reg) begin
            o_bus_takeover_grant_n <= 1'b1;
            o_pins_oe <= 1'b1;
        end
    end

    // =================================================================
    // Processor side handshake
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_req_ready <= 1'b0;
        end else begin
            o_req_ready <= (state_next == ST_IDLE) && !grant && !(hold_sync_reg && !lock_reg);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_rsp <= '0;
        end else if (state_reg == ST_CYCLE && i_ack && !i_retry && finish) begin
            o_rsp.valid <= 1'b1;
            o_rsp.cache_fill <= cach_reg;
            o_rsp.rdata <= write_reg ? `DATA_RESET : rbuf_next;
        end else begin
            o_rsp.valid <= 1'b0;
            o_rsp.cache_fill <= 1'b0;
        end
    end

endmodule : bus_sizer

// =====================================================================
// One byte lane of the read assembly buffer: takes the byte that the
// acknowledged port width puts on this lane, or keeps the old one
module read_lane_capture #(
    parameter int LANE = 0
) (
    input wire logic [1:0] i_width,
    input wire logic [31:0] i_rdata,
    input wire logic i_keep,
    input wire logic [7:0] i_old,
    output logic [7:0] o_byte
);

    always_comb begin
        o_byte = i_old;
        if (i_keep) begin
            unique case (i_width)
                `WIDTH_32: o_byte = i_rdata[8*LANE +: 8];
                // A narrow port always answers on its lowest lanes
                `WIDTH_16: o_byte = i_rdata[8*(LANE%2) +: 8];
                default: o_byte = i_rdata[7:0];
            endcase
        end
    end

endmodule : read_lane_capture

// ===== test/bus_sizer_props.sv
/* Port checker for the bus sizing sequencer.
   Assumes a bind onto the bus_sizer top, one clock. */
`timescale 1ns/10ps
`include "bus_sizer_map.svh"
module bus_sizer_props
    import bus_sizer_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_srst,
    input wire op_rsp_type o_rsp,
    input wire bus_pins_type o_pins,
    input wire logic o_pins_oe,
    input wire logic o_data_oe,
    input wire logic i_ack,
    input wire logic i_retry,
    input wire logic [1:0] i_width,
    input wire logic i_takeover_req_n,
    input wire logic o_bus_takeover_grant_n
);
    // ========
    // Helpers
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);
    logic busy;
    logic wr;
    assign busy = o_pins.bus_status_code != `STATUS_IDLE;
    assign wr = o_pins.bus_status_code == `STATUS_WRITE;
    sequence gone_s; i_takeover_req_n [*3]; endsequence
    sequence done_s; i_ack && !i_retry && busy; endsequence
    // ========
    // Properties
    grant_drive_a: assert property (o_bus_takeover_grant_n == o_pins_oe) else $error("grant and drive differ");
    held_idle_a: assert property (!o_bus_takeover_grant_n |-> !busy) else $error("status busy while granted");
    grant_cause_a: assert property ($fell(o_bus_takeover_grant_n) |-> $past(!i_takeover_req_n, 2))
        else $error("grant without request");
    give_back_a: assert property (gone_s |=> o_bus_takeover_grant_n) else $error("grant kept");
    retry_same_a: assert property (i_ack && i_retry && busy |=> $stable(o_pins)) else $error("retry changed");
    one_write_a: assert property (done_s ##0 wr && i_width == `WIDTH_32 |=> !busy && o_rsp.valid)
        else $error("wide write not single");
    half_next_a: assert property (done_s ##0 i_width == `WIDTH_16 |=> !busy || o_pins.addr ==
        {$past(o_pins.addr[31:2]), ~$past(o_pins.addr[1]), 1'b0}) else $error("bad second word address");
    byte_next_a: assert property (done_s ##0 i_width == `WIDTH_8 |=> !busy || o_pins.addr ==
        {$past(o_pins.addr[31:2]), $past(o_pins.addr[1:0]) + 2'h1}) else $error("bad byte address");
    lane0_copy_a: assert property (wr |-> o_data_oe && o_pins.wdata[7:0] ==
        o_pins.wdata[8*o_pins.addr[1:0] +: 8]) else $error("lane 0 copy wrong");
    lane1_copy_a: assert property (wr && o_pins.addr[1:0] == 2'h3 |->
        o_pins.wdata[15:8] == o_pins.wdata[31:24]) else $error("lane 1 copy wrong");
endmodule : bus_sizer_props

// ===== test/bus_mem_model.sv
/* Memory on the far side: answers each cycle after a set wait,
   optionally once with a retry. Assumes bench sets the port width. */
`timescale 1ns/10ps
`include "bus_sizer_map.svh"
module bus_mem_model
    import bus_sizer_pkg::*;
(
    input wire logic i_clk,
    input wire bus_pins_type i_pins,
    input wire logic i_oe,
    input wire logic [1:0] i_width,
    input wire logic [3:0] i_wait,
    input wire logic i_retry_en,
    output logic o_ack,
    output logic o_retry,
    output logic [31:0] o_rdata
);
    // ========
    // Fixed doubleword, returned whatever the enables say
    localparam logic [31:0] MEM = 32'h4433_2211;
    logic [3:0] cnt_reg;
    logic retried_reg;
    logic [15:0] half;
    logic [7:0] one;
    assign half = i_pins.addr[1] ? MEM[31:16] : MEM[15:0];
    assign one = MEM[8*i_pins.addr[1:0] +: 8];
    initial begin
        {o_ack, o_retry, cnt_reg, retried_reg} = '0;
        o_rdata = 32'h5a5a_5a5a;
    end
    always @(posedge i_clk) begin
        if (i_oe && i_pins.bus_status_code != `STATUS_IDLE && !o_ack) begin
            cnt_reg <= cnt_reg + 4'h1;
            if (cnt_reg >= i_wait) begin
                o_ack <= 1'b1;
                o_retry <= i_retry_en && !retried_reg;
                retried_reg <= 1'b1;
                // Unconnected lanes carry inverted junk so nothing relies on them
                o_rdata <= i_width == `WIDTH_8 ? {~one, ~one, ~one, one} :
                    i_width == `WIDTH_16 ? {~half, half} : MEM;
            end
        end else begin
            {o_ack, o_retry, cnt_reg} <= '0;
            o_rdata <= ~o_rdata;
            if (i_pins.bus_status_code == `STATUS_IDLE) retried_reg <= 1'b0;
        end
    end
endmodule : bus_mem_model

// ===== test/bus_sizer_test.sv
/* Self-checking bench for the bus sizing sequencer.
   Assumes the memory model and checker files compile before it. */
`timescale 1ns/10ps
`include "bus_sizer_map.svh"
module bus_sizer_test
    import bus_sizer_pkg::*;
;
    logic clk, srst, req_valid, ready, pins_oe, data_oe, ack, retry, take_n, grant_n, retry_en, fill;
    op_req_type req;
    op_rsp_type rsp;
    bus_pins_type pins;
    logic [1:0] width;
    logic [3:0] wait_n;
    logic [31:0] rdata, got;
    int fail_count, n_tests, cycles;
    bus_pins_type cyc[$];
    bus_sizer dut_u (.i_clk(clk), .i_srst(srst), .i_req(req), .i_req_valid(req_valid), .o_req_ready(ready),
        .o_rsp(rsp), .o_pins(pins), .o_pins_oe(pins_oe), .o_data_oe(data_oe), .i_ack(ack), .i_retry(retry),
        .i_width(width), .i_rdata(rdata), .i_takeover_req_n(take_n), .o_bus_takeover_grant_n(grant_n));
    bus_mem_model mem_u (.i_clk(clk), .i_pins(pins), .i_oe(pins_oe), .i_width(width), .i_wait(wait_n),
        .i_retry_en(retry_en), .o_ack(ack), .o_retry(retry), .o_rdata(rdata));
    always #50 clk = ~clk;
    always @(posedge clk) if (ack && !retry && pins.bus_status_code != `STATUS_IDLE) cyc.push_back(pins);
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            print_verdict;
        end
    end
    // ========
    // Shared tasks
    task print_verdict;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    task chk(input logic [31:0] a, input logic [31:0] e);
        n_tests++;
        if (a !== e) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e);
        end
    endtask : chk
    // Table holds {addr[7:0], enables} per cycle, first cycle lowest
    task run(input logic [31:0] a, input logic [3:0] mode, input logic [1:0] w, input int n, input logic [47:0] tab);
        int i;
        @(negedge clk);
        cyc = {};
        width = w;
        req = '{a, mode[3:2], mode[1], mode[0], 1'b0, 32'h4433_2211};
        req.locked = mode[1:0] == 2'h3;
        req.cacheable = mode[1:0] == 2'h1;
        req.write = mode[1:0] == 2'h2;
        req_valid = 1;
        for (i = 0; i < 50 && !ready; i++) @(negedge clk);
        @(negedge clk);
        req_valid = 0;
        for (i = 0; i < 200 && !rsp.valid; i++) @(negedge clk);
        chk(rsp.valid, 1);
        got = rsp.rdata;
        fill = rsp.cache_fill;
        chk(cyc.size(), n);
        for (i = 0; i < n; i++) chk({cyc[i].addr[7:0], cyc[i].byte_lane_enables_n}, 32'(tab[12*i +: 12]));
    endtask : run
    task wait_grant(input logic v);
        for (int i = 0; i < 8 && grant_n !== v; i++) @(negedge clk);
    endtask : wait_grant
    // ========
    // Scenarios; mode is {size, write, cacheable} or {size, 2'h3} for locked read
    task t_reads;
        run(5, 4'h4, `WIDTH_16, 2, 48'h06b_059);
        chk(got, 32'h0033_2200);
        run(4, 4'h1, `WIDTH_16, 2, 48'h060_04e);
        chk(fill, 1'b1);
        chk(got, 32'h4433_2211);
        run(4, 4'h0, `WIDTH_16, 1, 48'h04e);
        run(5, 4'h1, `WIDTH_8, 4, 48'h040_070_060_05d);
        run(5, 4'h4, `WIDTH_8, 2, 48'h06b_059);
    endtask : t_reads
    task t_writes;
        run(6, 4'h2, `WIDTH_32, 1, 48'h06b);
        chk(cyc[0].wdata[7:0], 8'h33);
        retry_en = 1;
        run(4, 4'he, `WIDTH_16, 2, 48'h063_040);
        chk(cyc[1].wdata[15:0], 16'h4433);
        retry_en = 0;
        run(5, 4'ha, `WIDTH_8, 3, 48'h077_063_051);
        chk({cyc[2].wdata[7:0], cyc[1].wdata[7:0], cyc[0].wdata[7:0]}, 24'h443322);
        run(7, 4'h2, `WIDTH_32, 1, 48'h077);
        chk(cyc[0].wdata[15:0], 16'h4444);
    endtask : t_writes
    task t_hold;
        take_n = 0;
        wait_grant(0);
        chk({grant_n, pins_oe, pins.bus_status_code}, {2'b00, `STATUS_IDLE});
        take_n = 1;
        wait_grant(1);
        chk(grant_n, 1);
    endtask : t_hold
    task t_lock;
        wait_n = 3;
        fork
            run(5, 4'h7, `WIDTH_8, 2, 48'h06b_059);
            begin
                repeat (3) @(negedge clk);
                take_n = 0;
            end
        join
        repeat (5) @(negedge clk);
        chk(grant_n, 1);
        run(5, 4'h6, `WIDTH_8, 2, 48'h06b_059);
        wait_grant(0);
        chk(grant_n, 0);
        take_n = 1;
        wait_grant(1);
    endtask : t_lock
    initial begin
        clk = 0;
        srst = 1;
        req = '0;
        req_valid = 0;
        take_n = 1;
        width = `WIDTH_32;
        wait_n = 0;
        retry_en = 0;
        repeat (3) @(negedge clk);
        srst = 0;
        chk({grant_n, pins_oe, pins.byte_lane_enables_n}, {2'b11, `BE_ALL_OFF_N});
        t_reads;
        t_writes;
        t_hold;
        t_lock;
        print_verdict;
    end
endmodule : bus_sizer_test
bind bus_sizer bus_sizer_props chk_u (.i_clk(i_clk), .i_srst(i_srst), .o_rsp(o_rsp), .o_pins(o_pins),
    .o_pins_oe(o_pins_oe), .o_data_oe(o_data_oe), .i_ack(i_ack), .i_retry(i_retry), .i_width(i_width),
    .i_takeover_req_n(i_takeover_req_n), .o_bus_takeover_grant_n(o_bus_takeover_grant_n));
